// ---- hdl/abz_uvw_encoder_emulator.v ----
// Purpose : Turns a 12-bit absolute angle into ABZ quadrature, index and UVW
//           block-commutation outputs, configured over AXI4-Lite.
// Assumes : The angle comes from logic on clk; one clock at 10 MHz.
// Notes   : The output state is recomputed on every update enable pulse.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "abz_uvw_map.vh"

module abz_uvw_encoder_emulator #(
    parameter ADDR_W   = 8,                 // Register bus address width.
    parameter HYST_LSB = 2                  // Hysteresis in angle LSBs, above the noise.
) (
    input  wire              clk,
    input  wire              sys_rst,
    input  wire [11:0]       angle,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire [2:0]        s_axi_awprot,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    output reg  [1:0]        s_axi_bresp,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire [2:0]        s_axi_arprot,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               enc_a,
    output reg               enc_b,
    output reg               enc_z,
    output reg               hall_u,
    output reg               hall_v,
    output reg               hall_w
);

    // ------------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------------
    // The clock is slower than the update rate, so the cycle count floors at one
    // and every clock cycle becomes an update; the output then moves slower
    // than the nominal rate, which only limits the top speed that is tracked.
    localparam integer UPD_RAW  = `CLK_RATE_HZ / `UPDATE_RATE_HZ;
    localparam integer UPD_CYC  = (UPD_RAW < 1) ? 1 : UPD_RAW;
    localparam [11:0]  HYST     = HYST_LSB[11:0];

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Scales a 12-bit angle to a step index out of mul steps per turn.
    function [10:0] scale_pos;
        input [11:0] ang;
        input [10:0] mul;
        reg   [22:0] prod;
        begin
            prod      = {11'h000, ang} * {12'h000, mul};
            scale_pos = prod[22:12];
        end
    endfunction

    // Decides one step of a hysteresis-guarded counter: 01 up, 10 down, 00 hold.
    // The lagged angle must reach the next step before a move up, the led angle
    // must fall below the current step before a move down.
    function [1:0] step_dir;
        input [10:0] pos_lag;
        input [10:0] pos_lead;
        input [10:0] cnt;
        input [10:0] modulus;
        reg   [10:0] fwd;
        reg   [10:0] back;
        begin
            fwd  = (pos_lag >= cnt) ? (pos_lag - cnt) : (pos_lag + modulus - cnt);
            back = (cnt >= pos_lead) ? (cnt - pos_lead) : (cnt + modulus - pos_lead);
            if ((pos_lag != cnt) && (fwd <= {1'b0, modulus[10:1]})) begin
                step_dir = 2'h1;
            end else if ((pos_lead != cnt) && (back <= {1'b0, modulus[10:1]})) begin
                step_dir = 2'h2;
            end else begin
                step_dir = 2'h0;
            end
        end
    endfunction

    // Moves a counter one step around its modulus.
    function [10:0] step_cnt;
        input [10:0] cnt;
        input [10:0] modulus;
        input [1:0]  dir;
        begin
            if (dir == 2'h1) begin
                step_cnt = (cnt == modulus - 11'h001) ? 11'h000 : cnt + 11'h001;
            end else if (dir == 2'h2) begin
                step_cnt = (cnt == 11'h000) ? modulus - 11'h001 : cnt - 11'h001;
            end else begin
                step_cnt = cnt;
            end
        end
    endfunction

    // Register select shared by the read and the write path.
    function [2:0] reg_sel;
        input [ADDR_W-1:0] addr;
        begin
            case (addr[7:0])
                `ADDR_INDEX_COUNT_LOW: reg_sel = 3'h1;
                `ADDR_COUNT_HIGH:      reg_sel = 3'h2;
                `ADDR_COMMUTATION_CFG: reg_sel = 3'h3;
                `ADDR_OUTPUT_STATUS:   reg_sel = 3'h4;
                default:               reg_sel = 3'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    reg  [7:0]        index_count_low_q;   // Index shape and low pulse count bits.
    reg  [7:0]        count_high_q;        // High pulse count bits.
    reg  [7:0]        commutation_cfg_q;   // Pole pair code.
    reg  [ADDR_W-1:0] wr_addr_q;           // Held write address.
    reg  [7:0]        wr_byte_q;           // Held low data byte.
    reg               wr_lane_q;           // Low byte lane was enabled.
    reg               aw_have_q;           // Write address taken.
    reg               w_have_q;            // Write data taken.

    wire [7:0] pulses_per_turn_code = {count_high_q[`PPT_HIGH_MSB:`PPT_HIGH_LSB],
                                       index_count_low_q[`PPT_LOW_MSB:`PPT_LOW_LSB]};
    wire [3:0] index_shape_code     = index_count_low_q[`ISHAPE_MSB:`ISHAPE_LSB];
    wire [2:0] pole_pair_code       = commutation_cfg_q[`POLE_MSB:`POLE_LSB];

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    // Address and data are taken in either order; the register is written once
    // both are held, and the response is raised at the same edge as the write.
    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready     <= 1'b1;
            s_axi_wready      <= 1'b1;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `RESP_OKAY;
            aw_have_q         <= 1'b0;
            w_have_q          <= 1'b0;
            wr_addr_q         <= {ADDR_W{1'b0}};
            wr_byte_q         <= 8'h00;
            wr_lane_q         <= 1'b0;
            index_count_low_q <= `RST_INDEX_COUNT_LOW;
            count_high_q      <= `RST_COUNT_HIGH;
            commutation_cfg_q <= `RST_COMMUTATION_CFG;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                wr_addr_q     <= s_axi_awaddr;
                aw_have_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wr_byte_q    <= s_axi_wdata[7:0];
                wr_lane_q    <= s_axi_wstrb[0];
                w_have_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Both halves held and no answer pending: commit the write.
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bresp  <= (reg_sel(wr_addr_q) == 3'h0) ? `RESP_SLVERR : `RESP_OKAY;
                if (wr_lane_q) begin
                    case (reg_sel(wr_addr_q))
                        3'h1:    index_count_low_q <= wr_byte_q;
                        3'h2:    count_high_q      <= wr_byte_q;
                        3'h3:    commutation_cfg_q <= wr_byte_q;
                        default: ;                  // Status is read-only.
                    endcase
                end
            end
            // Answer taken: open both input channels again.
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Update enable
    // ------------------------------------------------------------------------
    reg  [15:0] upd_cnt_q;                 // Divider towards the update rate.
    reg         upd_en_q;                  // One-cycle update pulse.

    // A divider gives one update pulse every UPD_CYC clocks, here every clock.
    always @(posedge clk) begin
        if (sys_rst) begin
            upd_cnt_q <= 16'h0000;
            upd_en_q  <= 1'b0;
        end else if (upd_cnt_q == UPD_CYC[15:0] - 16'h0001) begin
            upd_cnt_q <= 16'h0000;
            upd_en_q  <= 1'b1;
        end else begin
            upd_cnt_q <= upd_cnt_q + 16'h0001;
            upd_en_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Step counters with hysteresis
    // ------------------------------------------------------------------------
    reg  [10:0] edge_cnt_q;                // Quadrature edge index, 0 at zero angle.
    reg  [10:0] state_cnt_q;               // Commutation state index.
    reg  [7:0]  ppt_seen_q;                // Pulse count the edge counter was built on.
    reg  [2:0]  pole_seen_q;               // Pole code the state counter was built on.
    reg         started_q;                 // Counters hold a valid position.

    wire [8:0]  pulses      = {1'b0, pulses_per_turn_code} + 9'h001;
    wire [10:0] edges       = {pulses, 2'b00};
    wire [3:0]  pairs       = {1'b0, pole_pair_code} + 4'h1;
    wire [10:0] states      = {5'h00, pairs, 2'b00} + {6'h00, pairs, 1'b0};
    wire [11:0] ang_lag     = angle - HYST;
    wire [11:0] ang_lead    = angle + HYST;
    wire [1:0]  edge_dir    = step_dir(scale_pos(ang_lag, edges),
                                       scale_pos(ang_lead, edges),
                                       edge_cnt_q, edges);
    wire [1:0]  state_dir   = step_dir(scale_pos(ang_lag, states),
                                       scale_pos(ang_lead, states),
                                       state_cnt_q, states);
    wire        edge_reload = !started_q || (ppt_seen_q != pulses_per_turn_code);
    wire        state_reload = !started_q || (pole_seen_q != pole_pair_code);
    wire [10:0] edge_cnt_d  = edge_reload ? scale_pos(angle, edges)
                                          : step_cnt(edge_cnt_q, edges, edge_dir);
    wire [10:0] state_cnt_d = state_reload ? scale_pos(angle, states)
                                           : step_cnt(state_cnt_q, states, state_dir);

    // Each update moves each counter by one step at most; after reset or a new
    // setting the counter loads the plain position, since the old count means
    // nothing under a different step size.
    always @(posedge clk) begin
        if (sys_rst) begin
            edge_cnt_q  <= 11'h000;
            state_cnt_q <= 11'h000;
            ppt_seen_q  <= 8'h00;
            pole_seen_q <= 3'h0;
            started_q   <= 1'b0;
        end else if (upd_en_q) begin
            edge_cnt_q  <= edge_cnt_d;
            state_cnt_q <= state_cnt_d;
            ppt_seen_q  <= pulses_per_turn_code;
            pole_seen_q <= pole_pair_code;
            started_q   <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------------------
    reg  [10:0] z_start;                   // First edge index of the index pulse.
    reg  [10:0] z_width;                   // Index pulse length in edges.
    reg  [10:0] z_off;                     // Edge index counted from the pulse start.
    reg  [10:0] phase6;                    // Electrical phase 0..5.
    reg  [2:0]  uvw_d;                     // Next U, V, W levels.

    // The index starts a number of edges after zero and lasts a chosen count of
    // edges; code 0000 starts at the B fall and lasts two edges, half a pulse.
    always @* begin
        z_start = {9'h000, index_shape_code[1:0]};
        case (index_shape_code[3:2])
            2'h0:    z_width = 11'h002;
            2'h1:    z_width = 11'h003;
            2'h2:    z_width = 11'h004;
            default: z_width = 11'h001;
        endcase
        z_off = (edge_cnt_q >= z_start) ? (edge_cnt_q - z_start)
                                        : (edge_cnt_q + edges - z_start);
        phase6 = state_cnt_q % 11'd6;
        case (phase6[2:0])
            3'h0:    uvw_d = 3'b100;
            3'h1:    uvw_d = 3'b110;
            3'h2:    uvw_d = 3'b010;
            3'h3:    uvw_d = 3'b011;
            3'h4:    uvw_d = 3'b001;
            default: uvw_d = 3'b101;
        endcase
    end

    // Outputs are flops: A and B follow the two low bits of the edge count so
    // that a rising angle walks AB through 00, 10, 11, 01 with A ahead.
    always @(posedge clk) begin
        if (sys_rst) begin
            enc_a  <= 1'b0;
            enc_b  <= 1'b0;
            enc_z  <= 1'b0;
            hall_u <= 1'b0;
            hall_v <= 1'b0;
            hall_w <= 1'b0;
        end else begin
            enc_a  <= edge_cnt_q[0] ^ edge_cnt_q[1];
            enc_b  <= edge_cnt_q[1];
            enc_z  <= started_q && (z_off < z_width);
            hall_u <= started_q && uvw_d[2];
            hall_v <= started_q && uvw_d[1];
            hall_w <= started_q && uvw_d[0];
        end
    end

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    // One read at a time: the data is registered at the address handshake and
    // stays until the master takes it.
    always @(posedge clk) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            case (reg_sel(s_axi_araddr))
                3'h1:    s_axi_rdata <= {24'h000000, index_count_low_q};
                3'h2:    s_axi_rdata <= {24'h000000, count_high_q};
                3'h3:    s_axi_rdata <= {24'h000000, commutation_cfg_q};
                3'h4:    s_axi_rdata <= {5'h00, edge_cnt_q, 4'h0, state_cnt_q[5:0],
                                         hall_w, hall_v, hall_u, enc_z, enc_b, enc_a};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;  // Unmapped address.
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // abz_uvw_encoder_emulator

// ---- hdl/abz_uvw_map.vh ----
// Purpose : Register map, field layout, reset values and timing figures of the
//           incremental encoder emulator.
// Assumes : Included by bare name by the emulator design file only.
// Notes   : Register offsets are kept as indices; the byte address is four times
//           the index on the 32-bit register bus.
`ifndef ABZ_UVW_MAP_VH
`define ABZ_UVW_MAP_VH

// ----------------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------------
`define IDX_INDEX_COUNT_LOW   8'h04
`define IDX_COUNT_HIGH        8'h05
`define IDX_COMMUTATION_CFG   8'h07
`define IDX_OUTPUT_STATUS     8'h08
`define ADDR_INDEX_COUNT_LOW  8'h10
`define ADDR_COUNT_HIGH       8'h14
`define ADDR_COMMUTATION_CFG  8'h1C
`define ADDR_OUTPUT_STATUS    8'h20

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define PPT_LOW_MSB           7
`define PPT_LOW_LSB           6
`define PPT_HIGH_MSB          5
`define PPT_HIGH_LSB          0
`define ISHAPE_MSB            3
`define ISHAPE_LSB            0
`define POLE_MSB              2
`define POLE_LSB              0
`define RST_INDEX_COUNT_LOW   8'hC0
`define RST_COUNT_HIGH        8'h3F
`define RST_COMMUTATION_CFG   8'h00

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

// ----------------------------------------------------------------------------
// Timing: the system clock and the output update rate, both in hertz
// ----------------------------------------------------------------------------
`define CLK_RATE_HZ           10000000
`define UPDATE_RATE_HZ        16000000

`endif

// ---- verification/abz_uvw_encoder_emulator_asserts.sv ----
// Purpose : Concurrent checks on the encoder emulator's ports.
// Assumes : One clock, synchronous active-high reset.
// Notes   : Output checks wait out reset and configuration jumps.
`timescale 1ns/1ps
module abz_uvw_checker (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [11:0] angle,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        enc_a,
    input wire logic        enc_b,
    input wire logic        enc_z,
    input wire logic        hall_u,
    input wire logic        hall_v,
    input wire logic        hall_w
);
    // -------------------------------------------------------------
    // Helper logic
    // -------------------------------------------------------------
    logic [2:0] cnt_q;  // Cycles since reset, saturating.
    logic [1:0] bv_q;   // Recent write answers, which may jump the counters.
    wire quiet_w = (cnt_q == 3'h7) && !s_axi_bvalid && (bv_q == 2'h0);
    // A write may move outputs by several steps at once, so it is masked.
    always @(posedge clk) begin
        if (sys_rst) cnt_q <= 3'h0;
        else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
        bv_q <= {bv_q[0], s_axi_bvalid};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // -------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------
    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_still;
        (quiet_w && $stable(angle)) [*8];
    endsequence
    property p_ab_single;
        quiet_w |-> !($changed(enc_a) && $changed(enc_b));
    endproperty
    property p_hall_single;
        quiet_w |-> $countones({$changed(hall_u), $changed(hall_v), $changed(hall_w)}) <= 1;
    endproperty
    property p_hall_legal;
        quiet_w |-> ({hall_u, hall_v, hall_w} != 3'h0) && ({hall_u, hall_v, hall_w} != 3'h7);
    endproperty
    property p_still;
        s_still |=> $stable({enc_a, enc_b, enc_z, hall_u, hall_v, hall_w});
    endproperty
    property p_z_bfall;
        quiet_w && $rose(enc_z) |-> $fell(enc_b);
    endproperty
    property p_wresp;
        s_wtake |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
    endproperty
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    property p_rresp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_ab_single: assert property (p_ab_single)
        else $error("A and B moved together");
    a_hall_single: assert property (p_hall_single)
        else $error("two commutation lines moved together");
    a_hall_legal: assert property (p_hall_legal)
        else $error("commutation state illegal");
    a_still: assert property (p_still)
        else $error("outputs moved on a still angle");
    a_z_bfall: assert property (p_z_bfall)
        else $error("index rose off a B fall");
    a_wresp: assert property (p_wresp)
        else $error("write answer late");
    a_bdone: assert property (p_bdone)
        else $error("write channel not freed");
    a_rresp: assert property (p_rresp)
        else $error("read answer late");
endmodule // abz_uvw_checker

bind abz_uvw_encoder_emulator abz_uvw_checker abz_uvw_checker_inst (.clk, .sys_rst,
    .angle, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .enc_a, .enc_b, .enc_z, .hall_u, .hall_v, .hall_w);

// ---- verification/quad_counter_model.sv ----
// Purpose : Motor controller side: counts quadrature, index and commutation steps.
// Assumes : Outputs of the emulator sampled on clk.
// Notes   : A two-step jump of A and B counts as a bad step.
`timescale 1ns/1ps
module quad_counter_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clr,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_z,
    input wire logic hall_u,
    input wire logic hall_v,
    input wire logic hall_w,
    output int       pos_cnt,
    output int       z_rises,
    output int       hall_steps,
    output int       bad_steps
);
    logic [1:0] ph_q;  // Last quadrature phase, 0..3 in rising order.
    logic       z_q;   // Last index level.
    logic [2:0] h_q;   // Last commutation state.
    wire  [1:0] step_w = {enc_b, enc_a ^ enc_b} - ph_q;
    // Decoding keeps the history up to date even while counts are cleared.
    always @(posedge clk) begin
        ph_q <= {enc_b, enc_a ^ enc_b};
        z_q  <= enc_z;
        h_q  <= {hall_u, hall_v, hall_w};
        if (sys_rst || clr) begin
            pos_cnt <= 0; z_rises <= 0; hall_steps <= 0; bad_steps <= 0;
        end else begin
            if (step_w == 2'h1) pos_cnt <= pos_cnt + 1;
            if (step_w == 2'h3) pos_cnt <= pos_cnt - 1;
            if (step_w == 2'h2) bad_steps <= bad_steps + 1;
            if (enc_z && !z_q) z_rises <= z_rises + 1;
            if ({hall_u, hall_v, hall_w} != h_q) hall_steps <= hall_steps + 1;
        end
    end
endmodule // quad_counter_model

// ---- verification/abz_uvw_encoder_emulator_test.sv ----
// Purpose : Register and full-turn tests of the encoder emulator.
// Assumes : AXI4-Lite master tasks; angle stepped one LSB per clock within a move.
// Notes   : Turns are primed first so hysteresis starts in the same state.
`timescale 1ns/1ps
module abz_uvw_encoder_emulator_test;
    logic        clk = 1'b0, sys_rst = 1'b1, clr = 1'b0;
    logic [11:0] angle = 12'h800;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        enc_a, enc_b, enc_z, hall_u, hall_v, hall_w;
    int          pos_cnt, z_rises, hall_steps, bad_steps;
    int          error_cnt = 0, n_checks = 0, cyc = 0;
    abz_uvw_encoder_emulator abz_uvw_encoder_emulator_inst (
        .clk, .sys_rst, .angle, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .enc_a, .enc_b, .enc_z, .hall_u, .hall_v, .hall_w);
    quad_counter_model quad_counter_model_inst (.clk, .sys_rst, .clr, .enc_a, .enc_b,
        .enc_z, .hall_u, .hall_v, .hall_w, .pos_cnt, .z_rises, .hall_steps, .bad_steps);
    initial forever #50 clk = ~clk;
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Each channel holds until its ready is sampled high at a rising edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp; s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk); s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata; s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'h0);
    endtask
    task automatic move(input int dir, input int n);
        repeat (n) begin
            @(posedge clk); angle <= (dir > 0) ? angle + 12'h1 : angle - 12'h1;
        end
        repeat (8) @(posedge clk);
    endtask
    task automatic clear;
        clr <= 1'b1; @(posedge clk); clr <= 1'b0;
    endtask
    task automatic turn(input int dir, input int m, input int s);
        move(dir, 16); clear; move(dir, 4096);
        chk(32'(pos_cnt), 32'(dir * m));
        chk(32'(z_rises), 32'h1);
        chk(32'(hall_steps), 32'(s));
        chk(32'(bad_steps), 32'h0);
    endtask
    // ---------------------------------------------------------------
    // Timeout and main sequence
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin error_cnt++; stop_test; end
    end
    initial begin
        logic [1:0] r; logic [31:0] d; logic [7:0] p; logic [2:0] c; int k;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h10, d); chk(d, 32'hC0);
        rd(8'h14, d); chk(d, 32'h3F);
        wr(8'h30, 32'h5, r); chk(32'(r), 32'h2);
        $display("register test done");
        for (k = 0; k < 3; k++) begin
            p = (k == 0) ? 8'h00 : (k == 1) ? 8'h77 : 8'hFF;
            c = (k == 0) ? 3'h0 : (k == 1) ? 3'h3 : 3'h7;
            wr(8'h10, {24'h0, p[1:0], 6'h00}, r); chk(32'(r), 32'h0);
            wr(8'h14, {26'h0, p[7:2]}, r);
            wr(8'h1C, {29'h0, c}, r);
            rd(8'h10, d); chk(d, {24'h0, p[1:0], 6'h00});
            rd(8'h14, d); chk(d, {26'h0, p[7:2]});
            rd(8'h1C, d); chk(d, {29'h0, c});
            turn(1, 4 * (p + 1), 6 * (c + 1));
            angle <= 12'h800; move(1, 0); clear;
            repeat (20) begin move(-1, 1); move(1, 1); end
            move(-1, 1);
            chk(32'(pos_cnt), 32'h0);
            chk(32'(hall_steps), 32'h0);
            turn(-1, 4 * (p + 1), 6 * (c + 1));
            $display("turn test %0d done", k);
        end
        stop_test;
    end
endmodule // abz_uvw_encoder_emulator_test
